// ==== rtl/cpu_clock_mode_select.v ====
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "clock_mode_regs.vh"

module cpu_clock_mode_select #(
  parameter PERIOD_W = 16
)(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Straps and external clock
  input wire [2:0] clock_mode_strap_bits,
  input wire ext_clock_input,
  // Generated clock, edge strobes, PLL running and clock fail flags
  output reg cpu_clk_r,
  output reg half_clock_tick_r,
  output reg cpu_rise_r,
  output reg cpu_fall_r,
  output reg pll_running_r,
  output reg clock_fail_r,
  // Interrupt
  output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

  // CPU edges per input period, zero for non-PLL modes
  function [4:0] edges_per_period;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_MUL_4: edges_per_period = `EDGES_MUL_4;
        `MODE_MUL_3: edges_per_period = `EDGES_MUL_3;
        `MODE_MUL_2: edges_per_period = `EDGES_MUL_2;
        `MODE_MUL_5: edges_per_period = `EDGES_MUL_5;
        `MODE_MUL_1P5: edges_per_period = `EDGES_MUL_1P5;
        `MODE_MUL_2P5: edges_per_period = `EDGES_MUL_2P5;
        default: edges_per_period = 5'h00;
      endcase
    end
  endfunction

  // Register read mux
  function [31:0] read_word;
    input [3:0] ofs;
    input [31:0] cfg;
    input [31:0] stat;
    input irq_st;
    input irq_mk;
    begin
      case (ofs)
        `OFS_SYSTEM_CONFIG: read_word = cfg;
        `OFS_CLOCK_STATUS: read_word = stat;
        `OFS_IRQ_STATUS: read_word = {31'h0000_0000, irq_st};
        `OFS_IRQ_MASK: read_word = {31'h0000_0000, irq_mk};
        default: read_word = 32'h0000_0000;
      endcase
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
// Strap capture

  reg [2:0] mode_r;
  reg captured_r;

  // Taken at the first edge after release; a strap cannot enter an async reset
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_r <= `MODE_MUL_4;
      captured_r <= 1'b0;
    end
    else if (!captured_r)
    begin
      mode_r <= clock_mode_strap_bits;
      captured_r <= 1'b1;
    end
  end

  wire mode_direct = (mode_r == `MODE_DIRECT);
  wire mode_prescale = (mode_r == `MODE_PRESCALE);
  wire mode_mult = !mode_direct && !mode_prescale;
  wire [4:0] mult_edges = edges_per_period(mode_r);

////////////////////////////////////////////////////////////////////////////////
// Register file

  reg [31:0] sys_cfg_r;
  reg irq_status_r;
  reg irq_mask_r;
  reg wr_pend_r;
  reg [3:0] wr_ofs_r;
  wire fail_event;

  wire addr_phase = hsel && htrans[1] && hready;
  wire wdog_disable = sys_cfg_r[`BIT_OSC_WDOG_DISABLE];
  wire [31:0] status_word = {25'h000_0000, captured_r, pll_running_r, clock_fail_r,
                             1'b0, mode_r};

  // Zero-wait slave: read data registered in the address phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 4'h0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // Writes outside the register window are dropped here, not decoded later
      wr_pend_r <= addr_phase && hwrite && (haddr[31:4] == 28'h000_0000);
      if (addr_phase)
      begin
        wr_ofs_r <= haddr[3:0];
        if (!hwrite)
          hrdata <= (haddr[31:4] == 28'h000_0000) ?
            read_word(haddr[3:0], sys_cfg_r, status_word, irq_status_r, irq_mask_r) :
            32'h0000_0000;
      end
    end
  end

  wire wr_cfg = wr_pend_r && (wr_ofs_r == `OFS_SYSTEM_CONFIG);
  wire wr_ist = wr_pend_r && (wr_ofs_r == `OFS_IRQ_STATUS);
  wire wr_msk = wr_pend_r && (wr_ofs_r == `OFS_IRQ_MASK);

  // Only the disable bit of the config word is writable; its other bits read as zero
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sys_cfg_r <= `RST_SYSTEM_CONFIG;
      irq_mask_r <= `RST_IRQ_MASK;
    end
    else
    begin
      if (wr_cfg)
        sys_cfg_r <= {27'h000_0000, hwdata[`BIT_OSC_WDOG_DISABLE], 4'h0};
      if (wr_msk)
        irq_mask_r <= hwdata[`BIT_IRQ_CLOCK_FAIL];
    end
  end

  // Sticky fail flag, write one to clear; a new event beats the clear
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_status_r <= 1'b0;
    else if (fail_event)
      irq_status_r <= 1'b1;
    else if (wr_ist && hwdata[`BIT_IRQ_CLOCK_FAIL])
      irq_status_r <= 1'b0;
  end

  // Level interrupt
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= (irq_status_r || fail_event) && irq_mask_r;
  end

////////////////////////////////////////////////////////////////////////////////
// Input edge detection

  reg ext_prev_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ext_prev_r <= 1'b0;
    else
      ext_prev_r <= ext_clock_input;
  end

  wire ext_rise = ext_clock_input && !ext_prev_r;
  wire ext_edge = ext_clock_input ^ ext_prev_r;

////////////////////////////////////////////////////////////////////////////////
// Free-running PLL and oscillator watchdog

  reg [3:0] free_cnt_r;
  reg free_clk_r;
  reg [4:0] wdog_cnt_r;

  // PLL stays on once failed, the CPU clock then depends on it
  wire pll_on = captured_r && (mode_mult || clock_fail_r || !wdog_disable);
  wire wdog_active = captured_r && !mode_mult && !wdog_disable && !clock_fail_r;
  wire free_tick = pll_on && (free_cnt_r == `FREE_RUN_HALF - 4'h1);
  wire free_rise = free_tick && !free_clk_r;

  // Free-running oscillator, held still when switched off
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      free_cnt_r <= 4'h0;
      free_clk_r <= 1'b0;
    end
    else if (!pll_on)
    begin
      free_cnt_r <= 4'h0;
      free_clk_r <= 1'b0;
    end
    else if (free_tick)
    begin
      free_cnt_r <= 4'h0;
      free_clk_r <= !free_clk_r;
    end
    else
      free_cnt_r <= free_cnt_r + 4'h1;
  end

  assign fail_event = wdog_active && free_rise && !ext_edge &&
                      (wdog_cnt_r == `WDOG_OVERFLOW - 5'h01);

  // Watchdog counter, cleared by every input transition
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wdog_cnt_r <= 5'h00;
      clock_fail_r <= 1'b0;
    end
    else
    begin
      if (!wdog_active || ext_edge)
        wdog_cnt_r <= 5'h00;
      else if (free_rise)
        wdog_cnt_r <= wdog_cnt_r + 5'h01;
      if (fail_event)
        clock_fail_r <= 1'b1;
    end
  end

  // PLL status output
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pll_running_r <= 1'b0;
    else
      pll_running_r <= pll_on;
  end

////////////////////////////////////////////////////////////////////////////////
// Multiplying PLL model

  reg [PERIOD_W-1:0] meas_cnt_r;
  reg [PERIOD_W-1:0] period_r;
  reg [PERIOD_W-1:0] acc_r;
  reg [PERIOD_W-1:0] acc_nxt;
  reg [PERIOD_W-1:0] period_nxt;
  reg mult_toggle;
  wire [PERIOD_W-1:0] step = {{(PERIOD_W-5){1'b0}}, mult_edges};
  // Rounding up the quarter step; truncation would stall three counts short of lock
  wire [PERIOD_W-1:0] round_up = {{(PERIOD_W-2){1'b0}}, 2'h3};

  // Phase accumulator: edges per input period over measured period
  always @*
  begin
    acc_nxt = acc_r + step;
    mult_toggle = 1'b0;
    if (acc_nxt >= period_r)
    begin
      acc_nxt = acc_nxt - period_r;
      mult_toggle = 1'b1;
    end
    // Quarter-step tracking keeps the frequency from jumping
    if (meas_cnt_r > period_r)
      period_nxt = period_r + ((meas_cnt_r - period_r + round_up) >> 2);
    else
      period_nxt = period_r - ((period_r - meas_cnt_r + round_up) >> 2);
  end

  // Period measurement and resync at each input rising edge
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meas_cnt_r <= {PERIOD_W{1'b0}};
      period_r <= `PERIOD_INIT;
      acc_r <= {PERIOD_W{1'b0}};
    end
    else if (!mode_mult)
    begin
      meas_cnt_r <= {PERIOD_W{1'b0}};
      acc_r <= {PERIOD_W{1'b0}};
    end
    else
    begin
      if (ext_rise)
      begin
        meas_cnt_r <= {{(PERIOD_W-1){1'b0}}, 1'b1};
        period_r <= period_nxt;
        acc_r <= acc_nxt >> 1;
      end
      else
      begin
        if (meas_cnt_r != {PERIOD_W{1'b1}})
          meas_cnt_r <= meas_cnt_r + {{(PERIOD_W-1){1'b0}}, 1'b1};
        acc_r <= acc_nxt;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// CPU clock generation

  reg cpu_clk_nxt;

  // Source select: fail overrides; prescaler toggles once per input period
  always @*
  begin
    cpu_clk_nxt = cpu_clk_r;
    if (!captured_r)
      cpu_clk_nxt = 1'b0;
    else if (clock_fail_r)
      cpu_clk_nxt = free_clk_r;
    else if (mode_direct)
      cpu_clk_nxt = ext_clock_input;
    else if (mode_prescale)
    begin
      if (ext_rise)
        cpu_clk_nxt = !cpu_clk_r;
    end
    else if (mult_toggle)
      cpu_clk_nxt = !cpu_clk_r;
  end

  // Each CPU edge marks one half clock period, both edges usable
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_clk_r <= 1'b0;
      half_clock_tick_r <= 1'b0;
      cpu_rise_r <= 1'b0;
      cpu_fall_r <= 1'b0;
    end
    else
    begin
      cpu_clk_r <= cpu_clk_nxt;
      half_clock_tick_r <= cpu_clk_nxt ^ cpu_clk_r;
      cpu_rise_r <= cpu_clk_nxt && !cpu_clk_r;
      cpu_fall_r <= !cpu_clk_nxt && cpu_clk_r;
    end
  end

endmodule

// ==== pkg/clock_mode_regs.vh ====
`ifndef CLOCK_MODE_REGS_VH
`define CLOCK_MODE_REGS_VH

// Register byte offsets, one aligned word each
`define OFS_SYSTEM_CONFIG 4'h0
`define OFS_CLOCK_STATUS 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_MASK 4'hC

// Field positions
`define BIT_OSC_WDOG_DISABLE 4
`define BIT_IRQ_CLOCK_FAIL 0
`define STAT_MODE_LSB 0
`define STAT_MODE_MSB 2
`define BIT_STAT_FAIL 4
`define BIT_STAT_PLL_ON 5
`define BIT_STAT_CAPTURED 6

// Reset values
`define RST_SYSTEM_CONFIG 32'h0000_0000
`define RST_IRQ_MASK 1'b0

// Clock mode strap codes
`define MODE_MUL_4 3'h7
`define MODE_MUL_3 3'h6
`define MODE_MUL_2 3'h5
`define MODE_MUL_5 3'h4
`define MODE_DIRECT 3'h3
`define MODE_MUL_1P5 3'h2
`define MODE_PRESCALE 3'h1
`define MODE_MUL_2P5 3'h0

// CPU edges per input period (twice the factor) for multiply modes
`define EDGES_MUL_4 5'h08
`define EDGES_MUL_3 5'h06
`define EDGES_MUL_2 5'h04
`define EDGES_MUL_5 5'h0A
`define EDGES_MUL_1P5 5'h03
`define EDGES_MUL_2P5 5'h05

// Watchdog overflow after this many free-running cycles
`define WDOG_OVERFLOW 5'h10

// Free-running half period in hclk cycles (8 ns each, about 7.8 MHz)
`define FREE_RUN_HALF 4'h8

// Initial input period guess in hclk cycles
`define PERIOD_INIT 16'h0040

`endif

// ==== sim/ext_clock_src.sv ====
`timescale 1ns/1ps
// Behavioural crystal or clock source at the input pin
module ext_clock_src (
  // Clock and control
  input wire hclk,
  input wire run,
  input wire [7:0] hi_len,
  input wire [7:0] lo_len,
  // Pin
  output reg ext_clock_input
);
  reg [7:0] cnt_r;
  ////////////////
  // Power-up state
  initial
  begin
    ext_clock_input = 1'b0;
    cnt_r = 8'h00;
  end
  // Dropping run freezes the level, the way a dead crystal looks
  always @(posedge hclk)
  begin
    if (run)
    begin
      if (cnt_r >= (ext_clock_input ? hi_len : lo_len) - 8'h01)
      begin
        cnt_r <= 8'h00;
        ext_clock_input <= ~ext_clock_input;
      end
      else
        cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// ==== sim/clock_mode_sva.sv ====
`timescale 1ns/1ps
// Port watcher for the clock mode selector
module clock_mode_sva (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Watched ports
  input wire [2:0] clock_mode_strap_bits,
  input wire ext_clock_input,
  input wire cpu_clk_r,
  input wire half_clock_tick_r,
  input wire cpu_rise_r,
  input wire cpu_fall_r,
  input wire pll_running_r,
  input wire clock_fail_r,
  input wire hreadyout,
  input wire hresp,
  input wire irq
);
  reg [2:0] mode_r;
  reg [1:0] age_r;
  reg [8:0] still_r;
  wire run_w = age_r == 2'h3;
  wire wd_w = mode_r == 3'h1 || mode_r == 3'h3;
  ////////////////
  // Mirror the strap capture, later strap moves must not matter
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_r <= 3'h0;
      age_r <= 2'h0;
    end
    else
    begin
      if (age_r == 2'h0)
        mode_r <= clock_mode_strap_bits;
      if (!run_w)
        age_r <= age_r + 2'h1;
    end
  end
  // Cycles since the last input edge, saturating
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      still_r <= 9'h000;
    else if ($changed(ext_clock_input))
      still_r <= 9'h000;
    else if (still_r != 9'h1FF)
      still_r <= still_r + 9'h001;
  end
  ////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  direct_follow_a:
    assert property (run_w && mode_r == 3'h3 && !clock_fail_r |-> cpu_clk_r == $past(ext_clock_input))
    else $error("cpu clock not tracking input");
  pll_mul_a:
    assert property (run_w && !wd_w |-> pll_running_r && !clock_fail_r)
    else $error("pll off in multiply mode");
  tick_after_a:
    assert property ($changed(cpu_clk_r) |-> half_clock_tick_r)
    else $error("no tick with cpu edge");
  rise_dir_a:
    assert property (cpu_rise_r |-> half_clock_tick_r && cpu_clk_r && !$past(cpu_clk_r))
    else $error("rise strobe without rise");
  fall_dir_a:
    assert property (cpu_fall_r |-> half_clock_tick_r && !cpu_clk_r && $past(cpu_clk_r))
    else $error("fall strobe without fall");
  bus_okay_a:
    assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  fail_hold_a:
    assert property (clock_fail_r |=> clock_fail_r)
    else $error("fail flag dropped");
  fail_pll_a:
    assert property (clock_fail_r |-> pll_running_r)
    else $error("pll off after fail");
  irq_cause_a:
    assert property (irq |-> clock_fail_r)
    else $error("irq without fail");
  wdog_time_a:
    assert property ($rose(clock_fail_r) |-> still_r >= 9'h0EC && still_r <= 9'h12C)
    else $error("watchdog overflow at wrong time");
  cover property ($rose(clock_fail_r));
  cover property (cpu_rise_r && mode_r == 3'h1);
  cover property ($fell(irq));
endmodule

// ==== sim/cpu_clock_mode_select_bench.sv ====
`timescale 1ns/1ps
`include "clock_mode_regs.vh"
module cpu_clock_mode_select_bench;
  // Ticks per input period for strap codes 7 down to 0
  localparam [39:0] TPP = {5'h08, 5'h06, 5'h04, 5'h0A, 5'h02, 5'h03, 5'h01, 5'h05};
  reg hclk, hresetn, hsel, hwrite, run;
  reg [1:0] htrans;
  reg [2:0] strap;
  reg [7:0] hi_len, lo_len;
  reg [31:0] haddr, hwdata, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, ext, cpu_clk, tick, rise, fall, pll_on, fail, irq;
  integer bad_count, compares, cyc;
  cpu_clock_mode_select uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clock_mode_strap_bits(strap),
    .ext_clock_input(ext), .cpu_clk_r(cpu_clk), .half_clock_tick_r(tick), .cpu_rise_r(rise),
    .cpu_fall_r(fall), .pll_running_r(pll_on), .clock_fail_r(fail), .irq(irq));
  ext_clock_src src (.hclk(hclk), .run(run), .hi_len(hi_len), .lo_len(lo_len),
    .ext_clock_input(ext));
  ////////////////
  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wait_ready;
  begin
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  end
  endtask
  // One single word transfer, read data lands in rd
  task bus(input w, input [31:0] a, input [31:0] d);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  end
  endtask
  task rst(input [2:0] code);
  begin
    hresetn <= 1'b0;
    strap <= code;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    strap <= ~code;
  end
  endtask
  task count_ticks(output integer n);
  begin
    n = 0;
    repeat (256)
    begin
      @(posedge hclk);
      n = n + (tick === 1'b1);
    end
  end
  endtask
  ////////////////
  task t_modes;
    integer m, n, e;
  begin
    for (m = 0; m < 8; m = m + 1)
    begin
      rst(m[2:0]);
      repeat (3072) @(posedge hclk);
      count_ticks(n);
      e = TPP[m*5 +: 5] * 16;
      chk(n >= e - 2 && n <= e + 2, 1);
      bus(1'b0, `OFS_CLOCK_STATUS, 0);
      chk(rd, 32'h0000_0060 | m);
    end
    $display("modes test done");
  end
  endtask
  task t_wdog;
    integer n;
  begin
    hi_len <= 8'h03;
    lo_len <= 8'h03;
    rst(`MODE_DIRECT);
    bus(1'b0, `OFS_IRQ_MASK, 0);
    chk(rd, 0);
    run <= 1'b0;
    n = 0;
    while (fail !== 1'b1 && n < 300)
    begin
      @(posedge hclk);
      n = n + 1;
    end
    chk(n < 300, 1);
    repeat (3) @(posedge hclk);
    chk(irq, 0);
    bus(1'b1, `OFS_IRQ_MASK, 1);
    repeat (3) @(posedge hclk);
    chk(irq, 1);
    run <= 1'b1;
    bus(1'b1, `OFS_IRQ_STATUS, 1);
    repeat (3) @(posedge hclk);
    chk(irq, 0);
    count_ticks(n);
    chk(n >= 31 && n <= 33, 1);
    bus(1'b0, `OFS_CLOCK_STATUS, 0);
    chk(rd, 32'h0000_0073);
    $display("watchdog test done");
  end
  endtask
  task t_cfg;
  begin
    rst(`MODE_PRESCALE);
    bus(1'b0, `OFS_SYSTEM_CONFIG, 0);
    chk(rd, `RST_SYSTEM_CONFIG);
    chk(pll_on, 1);
    bus(1'b1, `OFS_SYSTEM_CONFIG, 32'hFFFF_FFFF);
    bus(1'b0, `OFS_SYSTEM_CONFIG, 0);
    chk(rd, 32'h0000_0010);
    run <= 1'b0;
    repeat (400) @(posedge hclk);
    chk(pll_on, 0);
    chk(fail, 0);
    run <= 1'b1;
    bus(1'b1, 32'h0000_0010, 0);
    bus(1'b0, 32'h0000_0010, 0);
    chk(rd, 0);
    bus(1'b0, `OFS_SYSTEM_CONFIG, 0);
    chk(rd, 32'h0000_0010);
    $display("config test done");
  end
  endtask
  ////////////////
  task end_sim;
  begin
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // Free running clock, 8 ns period
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Hang guard well past the expected run length
  always @(posedge hclk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end
  initial
  begin
    bad_count = 0;
    compares = 0;
    cyc = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    strap = 3'h7;
    run = 1'b1;
    hi_len = 8'h06;
    lo_len = 8'h0A;
    @(posedge hclk);
    t_modes;
    t_wdog;
    t_cfg;
    end_sim;
  end
endmodule
bind cpu_clock_mode_select clock_mode_sva chk_i (.hclk(hclk), .hresetn(hresetn),
  .clock_mode_strap_bits(clock_mode_strap_bits), .ext_clock_input(ext_clock_input),
  .cpu_clk_r(cpu_clk_r), .half_clock_tick_r(half_clock_tick_r), .cpu_rise_r(cpu_rise_r),
  .cpu_fall_r(cpu_fall_r), .pll_running_r(pll_running_r), .clock_fail_r(clock_fail_r),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
